// file: pkg/irqf_regs.vh
// register map, field layout and reset values of the interrupt request flags
`ifndef IRQF_REGS_VH
`define IRQF_REGS_VH

// register indices, byte address is four times the index
`define IRQF_IDX_REQ_SECOND 10'h0F7
`define IRQF_IDX_REQ_FIRST 10'h0F6
`define IRQF_IDX_PIN_FUNC 10'h0F8
`define IRQF_IDX_EDGE_SEL 10'h0F9
`define IRQF_IDX_IRQ_STATUS 10'h0FA
`define IRQF_IDX_IRQ_CLEAR 10'h0FB
`define IRQF_IDX_IRQ_ENABLE 10'h0FC
`define IRQF_IDX_MSB 11
`define IRQF_IDX_LSB 2

// field positions of the request byte
`define IRQF_BIT_TIMER 7
`define IRQF_BIT_SERIAL 6
`define IRQF_BIT_RSVD 5
`define IRQF_PIN_MSB 4
`define IRQF_PIN_LSB 0
`define IRQF_BYTE_MSB 7
`define IRQF_BYTE_LANE 0

// masks
`define IRQF_PIN_ALL 5'h1F
`define IRQF_PIN2_MASK 5'h04

// reset and fixed values
`define IRQF_PIN_FLAG_RST 5'h00
`define IRQF_FLAG_RST 1'b0
`define IRQF_RSVD_READ 1'b1
`define IRQF_RSVD_STATUS 1'b0
`define IRQF_PIN_FUNC_RST 5'h00
`define IRQF_EDGE_SEL_RST 5'h00
`define IRQF_IRQ_EN_RST 8'h00
`define IRQF_TIMER_RST 8'h00
`define IRQF_TIMER_MAX 8'hFF
`define IRQF_TIMER_ZERO 8'h00
`define IRQF_WORD_ZERO 32'h00000000
`define IRQF_UPPER_ZERO 24'h000000
`define IRQF_PIN_ZERO 5'h00
`define IRQF_BYTE_ZERO 8'h00

`endif

// file: hdl/irqf_pin_edge.v
// pin synchroniser and per-pin edge detector
module irqf_pin_edge #(
  parameter NUM_PINS = 5
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // asynchronous pins
  input wire [NUM_PINS-1:0] pin_raw,
  // 1 selects rising, 0 falling
  input wire [NUM_PINS-1:0] rise_sel,
  // one-cycle edge pulses
  output wire [NUM_PINS-1:0] edge_pulse
);

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1) begin : g_pin
      reg meta_q;
      reg sync_q;
      reg hist_q;
      // meta_q feeds sync_q only, no logic looks at it
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
          hist_q <= 1'b1;
        end else begin
          meta_q <= pin_raw[g];
          sync_q <= meta_q;
          hist_q <= sync_q;
        end
      end
      // reset to high so an idle low-active pin gives no false edge
      assign edge_pulse[g] = rise_sel[g] ? (sync_q & ~hist_q) : (~sync_q & hist_q);
    end
  endgenerate

endmodule // irqf_pin_edge

// file: hdl/irqf_top.v
// interrupt request flag register with apb slave and interrupt output
`include "irqf_regs.vh"

// How it works
// - a pin flag sets when its pin is in interrupt mode and its chosen edge arrives.
// - writing 0 to a set pin flag clears it, alike for all five pins.
// - the serial flag sets whenever the serial unit finishes a transfer.
// - writing 0 to the set serial flag clears it.
// - the timer flag sets when the eight-bit timer count wraps from FF to 00.
// - writing 0 to the set timer flag clears it.
// - software can only clear flags, a 1 written to the request byte changes nothing, a 1 written to the clear register clears that flag.
// - on the reduced variant the serial flag and pin 2 flag read as 0.
module irqf_top #(
  parameter REDUCED_VARIANT = 0,
  parameter NUM_PINS = 5
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // interrupt pins, asynchronous
  input wire [NUM_PINS-1:0] ext_irq_pin,
  // serial unit, same clock
  input wire serial_done,
  // timer unit, same clock
  input wire [7:0] timer_count,
  // interrupt output
  output wire irq
);

  // flag state
  reg [NUM_PINS-1:0] pin_flag_q;
  reg [NUM_PINS-1:0] pin_flag_d;
  reg serial_flag_q;
  reg serial_flag_d;
  reg timer_flag_q;
  reg timer_flag_d;

  // configuration
  reg [NUM_PINS-1:0] pin_func_q;
  reg [NUM_PINS-1:0] pin_func_d;
  reg [NUM_PINS-1:0] edge_sel_q;
  reg [NUM_PINS-1:0] edge_sel_d;
  reg [7:0] irq_en_q;
  reg [7:0] irq_en_d;

  // timer history
  reg [7:0] timer_prev_q;

  // bus answer
  reg pready_q;
  reg pready_d;
  reg pslverr_q;
  reg pslverr_d;
  reg [31:0] prdata_q;
  reg [31:0] prdata_d;
  reg irq_q;
  reg irq_d;

  // read composition
  reg [7:0] rd_byte;
  reg rd_hit;

  wire [NUM_PINS-1:0] pin_edge;

  // variant availability
  wire serial_avail;
  wire [NUM_PINS-1:0] pin_avail;

  assign serial_avail = (REDUCED_VARIANT == 0);
  assign pin_avail = serial_avail ? `IRQF_PIN_ALL : (`IRQF_PIN_ALL & ~`IRQF_PIN2_MASK);

  // synchronised pins and edge pulses
  irqf_pin_edge #(
    .NUM_PINS(NUM_PINS)
  ) u_pin_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin_raw(ext_irq_pin),
    .rise_sel(edge_sel_q),
    .edge_pulse(pin_edge)
  );

  // address decode
  wire [9:0] acc_idx;
  wire hit_first;
  wire hit_second;
  wire hit_func;
  wire hit_edge;
  wire hit_status;
  wire hit_clear;
  wire hit_enable;

  assign acc_idx = paddr[`IRQF_IDX_MSB:`IRQF_IDX_LSB];
  assign hit_first = (acc_idx == `IRQF_IDX_REQ_FIRST);
  assign hit_second = (acc_idx == `IRQF_IDX_REQ_SECOND);
  assign hit_func = (acc_idx == `IRQF_IDX_PIN_FUNC);
  assign hit_edge = (acc_idx == `IRQF_IDX_EDGE_SEL);
  assign hit_status = (acc_idx == `IRQF_IDX_IRQ_STATUS);
  assign hit_clear = (acc_idx == `IRQF_IDX_IRQ_CLEAR);
  assign hit_enable = (acc_idx == `IRQF_IDX_IRQ_ENABLE);

  // transfer phases, one wait state so every answer is a flop
  wire acc_phase;
  wire acc_first;
  wire acc_done;
  wire wr_lane;

  assign acc_phase = psel & penable;
  assign acc_first = acc_phase & ~pready_q;
  assign acc_done = acc_phase & pready_q;
  assign wr_lane = acc_done & pwrite & pstrb[`IRQF_BYTE_LANE];

  wire wr_first;
  wire wr_func;
  wire wr_edge;
  wire wr_clear;
  wire wr_enable;

  assign wr_first = wr_lane & hit_first;
  assign wr_func = wr_lane & hit_func;
  assign wr_edge = wr_lane & hit_edge;
  assign wr_clear = wr_lane & hit_clear;
  assign wr_enable = wr_lane & hit_enable;

  // set events
  wire [NUM_PINS-1:0] pin_set;
  wire serial_set;
  wire timer_set;

  assign pin_set = pin_edge & pin_func_q & pin_avail;
  assign serial_set = serial_done & serial_avail;
  assign timer_set = (timer_prev_q == `IRQF_TIMER_MAX) &
                     (timer_count == `IRQF_TIMER_ZERO);

  // clear masks, a written 0 at the request byte or a written 1 at the clear register clears a flag
  wire [NUM_PINS-1:0] pin_clr;
  wire serial_clr;
  wire timer_clr;
  wire [NUM_PINS-1:0] pin_wr0;
  wire [NUM_PINS-1:0] pin_wr1;

  assign pin_wr0 = wr_first ? ~pwdata[`IRQF_PIN_MSB:`IRQF_PIN_LSB] : `IRQF_PIN_ZERO;
  assign pin_wr1 = wr_clear ? pwdata[`IRQF_PIN_MSB:`IRQF_PIN_LSB] : `IRQF_PIN_ZERO;
  assign pin_clr = pin_wr0 | pin_wr1;
  assign serial_clr = (wr_first & ~pwdata[`IRQF_BIT_SERIAL]) |
                      (wr_clear & pwdata[`IRQF_BIT_SERIAL]);
  assign timer_clr = (wr_first & ~pwdata[`IRQF_BIT_TIMER]) |
                     (wr_clear & pwdata[`IRQF_BIT_TIMER]);

  // pin flags
  always @* begin
    pin_flag_d = pin_flag_q & ~pin_clr;
    pin_flag_d = pin_flag_d | pin_set;
    pin_flag_d = pin_flag_d & pin_avail;
  end

  // serial flag
  always @* begin
    serial_flag_d = serial_flag_q & ~serial_clr;
    serial_flag_d = serial_flag_d | serial_set;
    serial_flag_d = serial_flag_d & serial_avail;
  end

  // timer flag
  always @* begin
    timer_flag_d = timer_flag_q & ~timer_clr;
    timer_flag_d = timer_flag_d | timer_set;
  end

  // configuration next values
  always @* begin
    pin_func_d = pin_func_q;
    if (wr_func) begin
      pin_func_d = pwdata[`IRQF_PIN_MSB:`IRQF_PIN_LSB];
    end
  end

  always @* begin
    edge_sel_d = edge_sel_q;
    if (wr_edge) begin
      edge_sel_d = pwdata[`IRQF_PIN_MSB:`IRQF_PIN_LSB];
    end
  end

  always @* begin
    irq_en_d = irq_en_q;
    if (wr_enable) begin
      irq_en_d = pwdata[`IRQF_BYTE_MSB:0];
    end
  end

  // assembled request bytes
  wire [7:0] req_byte;
  wire [7:0] status_byte;

  assign req_byte = {timer_flag_q, serial_flag_q, `IRQF_RSVD_READ, pin_flag_q};
  assign status_byte = {timer_flag_q, serial_flag_q, `IRQF_RSVD_STATUS, pin_flag_q};

  // read mux, clear register reads as zero
  always @* begin
    rd_byte = `IRQF_BYTE_ZERO;
    rd_hit = 1'b1;
    case (1'b1)
      hit_first: begin
        rd_byte = req_byte;
      end
      hit_second: begin
        rd_byte = `IRQF_BYTE_ZERO;
      end
      hit_func: begin
        rd_byte = {3'h0, pin_func_q};
      end
      hit_edge: begin
        rd_byte = {3'h0, edge_sel_q};
      end
      hit_status: begin
        rd_byte = status_byte;
      end
      hit_clear: begin
        rd_byte = `IRQF_BYTE_ZERO;
      end
      hit_enable: begin
        rd_byte = irq_en_q;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // answer formed in the first access cycle, shown in the second
  always @* begin
    pready_d = acc_first;
    pslverr_d = acc_first & ~rd_hit;
    prdata_d = prdata_q;
    if (acc_first) begin
      prdata_d = `IRQF_WORD_ZERO;
      if (!pwrite) begin
        prdata_d = {`IRQF_UPPER_ZERO, rd_byte};
      end
    end else if (acc_done) begin
      prdata_d = `IRQF_WORD_ZERO;
    end
  end

  // level interrupt from next flag state so it tracks without lag
  always @* begin
    irq_d = |({timer_flag_d, serial_flag_d, `IRQF_RSVD_STATUS, pin_flag_d} & irq_en_q);
  end

  // flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_flag_q <= `IRQF_PIN_FLAG_RST;
      serial_flag_q <= `IRQF_FLAG_RST;
      timer_flag_q <= `IRQF_FLAG_RST;
    end else begin
      pin_flag_q <= pin_flag_d;
      serial_flag_q <= serial_flag_d;
      timer_flag_q <= timer_flag_d;
    end
  end

  // configuration
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_func_q <= `IRQF_PIN_FUNC_RST;
      edge_sel_q <= `IRQF_EDGE_SEL_RST;
      irq_en_q <= `IRQF_IRQ_EN_RST;
    end else begin
      pin_func_q <= pin_func_d;
      edge_sel_q <= edge_sel_d;
      irq_en_q <= irq_en_d;
    end
  end

  // timer history, wrap seen only between two adjacent samples
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_prev_q <= `IRQF_TIMER_RST;
    end else begin
      timer_prev_q <= timer_count;
    end
  end

  // bus answer and interrupt
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= `IRQF_WORD_ZERO;
      irq_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      irq_q <= irq_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

endmodule // irqf_top

// file: testbench/irqf_sva.sv
// checker for the interrupt request flag block
module irqf_sva #(
  parameter REDUCED_VARIANT = 0,
  parameter NUM_PINS = 5
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // sources and output
  input wire [NUM_PINS-1:0] ext_irq_pin,
  input wire serial_done,
  input wire [7:0] timer_count,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] en_q;
  logic [7:0] tp_q;
  logic [NUM_PINS-1:0] p1_q;
  logic [NUM_PINS-1:0] p2_q;
  logic [NUM_PINS-1:0] p3_q;
  wire done = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
  wire wrap = tp_q == 8'hFF && timer_count == 8'h00;
  // no event can land at the write edge
  wire calm = !serial_done && !wrap && ext_irq_pin == p1_q && p1_q == p2_q && p2_q == p3_q;
  wire wr_req = done && paddr[11:2] == 10'h0F6;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 8'h00;
      tp_q <= 8'h00;
      p1_q <= '1;
      p2_q <= '1;
      p3_q <= '1;
    end else begin
      if (done && paddr[11:2] == 10'h0FC)
        en_q <= pwdata[7:0];
      tp_q <= timer_count;
      p1_q <= ext_irq_pin;
      p2_q <= p1_q;
      p3_q <= p2_q;
    end
  end
  sequence s_req;
    psel && !penable ##1 psel && penable;
  endsequence
  AST_WAIT_ONE: assert property (s_req |=> pready) else $error("late ready");
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready held");
  AST_ERR_READY: assert property (pslverr |-> pready) else $error("stray error");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h00000000)
    else $error("stray read data");
  AST_SERIAL_SET: assert property (REDUCED_VARIANT == 0 && serial_done && en_q[6] |=> irq)
    else $error("serial event lost");
  AST_TIMER_SET: assert property (wrap && en_q[7] |=> irq)
    else $error("timer wrap lost");
  AST_CLEAR: assert property (wr_req && pwdata[7:0] == 8'h00 && calm |=> !irq)
    else $error("flags not cleared");
  AST_WRITE_ONE: assert property (wr_req && pwdata[7:0] == 8'hFF && !irq && calm |=> !irq)
    else $error("write of one set a flag");
  AST_MASKED: assert property (en_q == 8'h00 && $past(en_q) == 8'h00 |-> !irq)
    else $error("masked request raised");
endmodule // irqf_sva

bind irqf_top irqf_sva #(.REDUCED_VARIANT(REDUCED_VARIANT), .NUM_PINS(NUM_PINS)) sva_i (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ext_irq_pin(ext_irq_pin), .serial_done(serial_done),
  .timer_count(timer_count), .irq(irq));

// file: testbench/irqf_partner.sv
// stand-in for the pins, the timer and the serial unit
module irqf_partner (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // bench commands
  input wire tmr_run,
  input wire ser_go,
  input wire [4:0] pin_set,
  // toward the block
  output logic [4:0] ext_irq_pin,
  output wire serial_done,
  output logic [7:0] timer_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // each high cycle is one finished transfer
  assign serial_done = ser_go;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count <= 8'h00;
      ext_irq_pin <= 5'h1F;
    end else begin
      timer_count <= timer_count + {7'h00, tmr_run};
      ext_irq_pin <= pin_set;
    end
  end
endmodule // irqf_partner

// file: testbench/irqf_top_tb.sv
// self-checking bench for the interrupt request flags
module irqf_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, irq2, err;
  logic tmr_run, ser_go, serial_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, prdata2, rd, rd2, seed, r;
  logic [3:0] pstrb;
  logic [4:0] ext_irq_pin, pin_set, x, h, c;
  logic [7:0] timer_count;
  int n_fail, tests_run;
  irqf_partner far (.pclk(pclk), .presetn(presetn), .tmr_run(tmr_run), .ser_go(ser_go),
    .pin_set(pin_set), .ext_irq_pin(ext_irq_pin), .serial_done(serial_done),
    .timer_count(timer_count));
  irqf_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_irq_pin(ext_irq_pin),
    .serial_done(serial_done), .timer_count(timer_count), .irq(irq));
  // reduced variant shares the bus, answers in step
  irqf_top #(.REDUCED_VARIANT(1)) dut_small (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata2), .pready(), .pslverr(), .ext_irq_pin(ext_irq_pin),
    .serial_done(serial_done), .timer_count(timer_count), .irq(irq2));
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // flags raised by one pin change
  function logic [4:0] hit(input logic [4:0] was, now, sel, fn);
    return fn & (was ^ now) & ~(now ^ sel);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tally_and_finish();
    $display("fails=%0d checks=%0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 16);
    rd = prdata;
    rd2 = prdata2;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (k == 16) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, tmr_run, ser_go} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    pin_set = 5'h1F;
    seed = 32'h00000008;
    n_fail = 0;
    tests_run = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    bus(0, 12'h3D8, 8'h00);
    chk(rd, 32'h20);
    chk(rd2, 32'h20);
    bus(1, 12'h3D8, 8'hFF);
    bus(0, 12'h3D8, 8'h00);
    chk(rd, 32'h20);
    bus(0, 12'h000, 8'h00);
    chk({31'h0, err}, 32'h1);
    bus(1, 12'h3F0, 8'hFF);
    ser_go <= 1'h1;
    @(posedge pclk);
    ser_go <= 1'h0;
    bus(0, 12'h3D8, 8'h00);
    chk(rd, 32'h60);
    chk(rd2, 32'h20);
    chk({irq2, irq}, 32'h1);
    bus(1, 12'h3D8, 8'hFF);
    bus(0, 12'h3D8, 8'h00);
    chk(rd, 32'h60);
    bus(1, 12'h3D8, 8'hBF);
    bus(0, 12'h3D8, 8'h00);
    chk(rd, 32'h20);
    tmr_run <= 1'h1;
    repeat (257) @(posedge pclk);
    tmr_run <= 1'h0;
    bus(0, 12'h3D8, 8'h00);
    chk(rd, 32'hA0);
    chk({31'h0, irq}, 32'h1);
    // masking hides the request, then a written 0 clears the flag
    bus(1, 12'h3F0, 8'h00);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    bus(1, 12'h3F0, 8'hFF);
    bus(1, 12'h3D8, 8'h00);
    bus(0, 12'h3D8, 8'h00);
    chk(rd, 32'h20);
    // all enabled and clear, so a written 1 that set a flag would show
    bus(1, 12'h3D8, 8'hFF);
    bus(0, 12'h3D8, 8'h00);
    chk(rd, 32'h20);
    chk({31'h0, irq}, 32'h0);
    // serial done held high across the clearing write
    ser_go <= 1'h1;
    bus(1, 12'h3D8, 8'h00);
    ser_go <= 1'h0;
    bus(0, 12'h3D8, 8'h00);
    chk(rd, 32'h60);
    bus(1, 12'h3EC, 8'h40);
    x = 5'h1F;
    for (int i = 0; i < 40; i++) begin
      r = xs();
      bus(1, 12'h3E0, {3'h0, r[4:0]});
      bus(1, 12'h3E4, {3'h0, r[9:5]});
      pin_set <= r[14:10];
      repeat (4) @(posedge pclk);
      h = hit(x, r[14:10], r[9:5], r[4:0]);
      c = r[19:15];
      bus(0, 12'h3E8, 8'h00);
      chk(rd, {27'h0, h});
      chk(rd2, {27'h0, h & 5'h1B});
      bus(1, 12'h3D8, {3'h0, c});
      bus(0, 12'h3D8, 8'h00);
      chk(rd, {27'h1, h & c});
      bus(1, 12'h3EC, 8'h1F);
      x = r[14:10];
    end
    // mid-run reset drops flags and configuration
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    bus(0, 12'h3D8, 8'h00);
    chk(rd, 32'h20);
    bus(0, 12'h3E8, 8'h00);
    chk(rd, 32'h0);
    bus(0, 12'h3E0, 8'h00);
    chk(rd, 32'h0);
    bus(0, 12'h3F0, 8'h00);
    chk(rd, 32'h0);
    tally_and_finish();
  end
endmodule // irqf_top_tb
